// File: include/slmr_pkg.sv
// Package: register map, field layout and carrier types of the soft limit block
package slmr_pkg;

    // ==========================================================
    // Register word indices (byte address is four times these)
    localparam logic [8:0] SLMR_IDX_LEFT     = 9'h034;
    localparam logic [8:0] SLMR_IDX_RIGHT    = 9'h035;
    localparam logic [8:0] SLMR_IDX_MSIDX    = 9'h036;
    localparam logic [8:0] SLMR_IDX_CUR      = 9'h037;
    localparam logic [8:0] SLMR_IDX_CFG      = 9'h040;
    localparam logic [8:0] SLMR_IDX_IRQ_STAT = 9'h041;
    localparam logic [8:0] SLMR_IDX_IRQ_CLR  = 9'h042;
    localparam logic [8:0] SLMR_IDX_IRQ_EN   = 9'h043;

    // ==========================================================
    // Widths and field positions
    localparam int SLMR_DW          = 32;
    localparam int SLMR_AW          = 11;
    localparam int SLMR_SELW        = 4;
    localparam int SLMR_MSIDX_W     = 10;
    localparam int SLMR_CUR_W       = 9;
    localparam int SLMR_PHASE_B_CURRENT_LSB   = 16;
    localparam int SLMR_PHASE_A_CURRENT_LSB   = 0;
    localparam int SLMR_CFG_SRC_BIT = 0;
    localparam int SLMR_EV_W        = 2;
    localparam int SLMR_EV_LEFT     = 0;
    localparam int SLMR_EV_RIGHT    = 1;

    // ==========================================================
    // Reset values and constants
    localparam logic [31:0] SLMR_LIMIT_RST   = 32'h0000_0000;
    localparam logic [9:0]  SLMR_MSIDX_RST   = 10'h000;
    localparam logic [8:0]  SLMR_PHASE_A_CURRENT_RST   = 9'h0f7;
    localparam logic [8:0]  SLMR_PHASE_B_CURRENT_RST   = 9'h000;
    localparam logic [9:0]  SLMR_PHASE_A_OFS = 10'h100;
    localparam logic        SLMR_CFG_SRC_RST = 1'h0;
    localparam logic [1:0]  SLMR_EV_RST      = 2'h0;

    // ==========================================================
    // Carrier types
    typedef struct packed {
        logic signed [31:0] left;
        logic signed [31:0] right;
    } slmr_limits_t;

    typedef struct packed {
        logic [8:0] phase_b_current;
        logic [8:0] phase_a_current;
    } slmr_cur_t;

    typedef struct packed {
        logic [9:0] addr_b;
        logic [9:0] addr_a;
    } slmr_tbl_addr_t;

endpackage : slmr_pkg

// File: src/slmr_cmp.sv
// Signed soft limit comparators producing registered left and right stops
module slmr_cmp
    import slmr_pkg::*;
(
    // Clock and reset
    input  wire logic               i_core_clk,
    input  wire logic               i_rst_b,
    // Positions and limits
    input  wire logic               i_src_enc,
    input  wire logic signed [31:0] i_enc_pos,
    input  wire logic signed [31:0] i_actual_pos,
    input  wire slmr_limits_t       i_limits,
    // Stops
    output logic                    o_stop_left,
    output logic                    o_stop_right
);

    logic signed [31:0] pos_sel;

    // ==========================================================
    // Source select and compare, every cycle
    always_comb begin
        pos_sel = i_src_enc ? i_enc_pos : i_actual_pos;
    end

    always_ff @(posedge i_core_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_stop_left <= 1'b0;
        end else begin
            o_stop_left <= (pos_sel <= i_limits.left);
        end
    end

    always_ff @(posedge i_core_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_stop_right <= 1'b0;
        end else begin
            o_stop_right <= (pos_sel >= i_limits.right);
        end
    end

    // ==========================================================
    // Assertions
    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (!i_rst_b);

    stop_left_enc_a: assert property (i_src_enc |=> o_stop_left == ($past(i_enc_pos) <= $past(i_limits.left)))
        else $error("left stop wrong for encoder source");
    stop_left_act_a: assert property (!i_src_enc |=> o_stop_left == ($past(i_actual_pos) <= $past(i_limits.left)))
        else $error("left stop wrong for actual position source");
    stop_right_enc_a: assert property (i_src_enc |=> o_stop_right == ($past(i_enc_pos) >= $past(i_limits.right)))
        else $error("right stop wrong for encoder source");
    stop_right_act_a: assert property (!i_src_enc |=> o_stop_right == ($past(i_actual_pos) >= $past(i_limits.right)))
        else $error("right stop wrong for actual position source");

endmodule : slmr_cmp

// File: src/slmr_top.sv
// Soft limit stops and microstep readback behind a classic Wishbone slave
//
// How it works
// - Encoder source selected: left stop while encoder position <= left limit, signed.
// - Actual source selected: left stop while actual position <= left limit, signed.
// - Encoder source selected: right stop while encoder position >= right limit, signed.
// - Actual source selected: right stop while actual position >= right limit, signed.
// - Both limits are full 32-bit signed read/write registers, reset to zero.
// - Read-only 10-bit microstep index of phase B table position, resets zero.
// - Phase A current is fetched at microstep index plus 256.
// - Bits 24:16 report unscaled 9-bit phase B table current, read-only.
// - Bits 8:0 report unscaled 9-bit phase A table current, read-only.
//
// Decided for this implementation: register access over Wishbone.
module slmr_top
    import slmr_pkg::*;
(
    // Clock and reset
    input  wire logic                    i_core_clk,
    input  wire logic                    i_rst_b,
    // Wishbone classic slave
    input  wire logic                    i_wb_cyc,
    input  wire logic                    i_wb_stb,
    input  wire logic                    i_wb_we,
    input  wire logic [SLMR_AW-1:0]      i_wb_adr,
    input  wire logic [SLMR_SELW-1:0]    i_wb_sel,
    input  wire logic [SLMR_DW-1:0]      i_wb_dat,
    output logic      [SLMR_DW-1:0]      o_wb_dat,
    output logic                         o_wb_ack,
    // Motion core
    input  wire logic signed [31:0]      i_enc_pos,
    input  wire logic signed [31:0]      i_actual_pos,
    input  wire logic [SLMR_MSIDX_W-1:0] i_microstep_index,
    // Sine table port
    output slmr_tbl_addr_t               o_tbl_addr,
    input  wire slmr_cur_t               i_tbl_data,
    // Stops and interrupt
    output logic                         o_stop_left,
    output logic                         o_stop_right,
    output logic                         o_irq
);

    // ==========================================================
    // Declarations
    slmr_limits_t            limits;
    logic                    src_enc;
    logic [SLMR_MSIDX_W-1:0] microstep_index;
    slmr_cur_t               phase_current;
    logic [SLMR_EV_W-1:0]    irq_stat;
    logic [SLMR_EV_W-1:0]    irq_en;
    logic [SLMR_EV_W-1:0]    stop_prev;
    logic [SLMR_EV_W-1:0]    stop_now;
    logic [SLMR_EV_W-1:0]    ev_set;
    logic [SLMR_EV_W-1:0]    ev_clr;
    logic [SLMR_EV_W-1:0]    next_irq_stat;
    logic [8:0]              wb_idx;
    logic                    wb_req;
    logic                    wb_wr;
    logic [SLMR_DW-1:0]      next_rd_data;

    // Byte-lane merge of a write into a stored word
    function automatic logic [31:0] lane_merge(input logic [31:0] old_val,
                                               input logic [31:0] new_val,
                                               input logic [3:0]  sel);
        logic [31:0] res;
        res = old_val;
        for (int b = 0; b < SLMR_SELW; b++) begin
            if (sel[b]) begin
                res[b*8 +: 8] = new_val[b*8 +: 8];
            end
        end
        return res;
    endfunction : lane_merge

    // ==========================================================
    // Bus decode
    always_comb begin
        wb_idx = i_wb_adr[SLMR_AW-1:2];
        wb_req = i_wb_cyc && i_wb_stb && !o_wb_ack;
        wb_wr  = wb_req && i_wb_we;
    end

    // One wait state; ack drops the cycle after it was given
    always_ff @(posedge i_core_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_wb_ack <= 1'b0;
        end else begin
            o_wb_ack <= wb_req;
        end
    end

    // ==========================================================
    // Soft limit registers
    always_ff @(posedge i_core_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            limits.left  <= SLMR_LIMIT_RST;
            limits.right <= SLMR_LIMIT_RST;
        end else if (wb_wr) begin
            if (wb_idx == SLMR_IDX_LEFT) begin
                limits.left <= lane_merge(limits.left, i_wb_dat, i_wb_sel);
            end
            if (wb_idx == SLMR_IDX_RIGHT) begin
                limits.right <= lane_merge(limits.right, i_wb_dat, i_wb_sel);
            end
        end
    end

    // ==========================================================
    // Configuration and interrupt enable
    always_ff @(posedge i_core_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            src_enc <= SLMR_CFG_SRC_RST;
        end else if (wb_wr && wb_idx == SLMR_IDX_CFG && i_wb_sel[0]) begin
            src_enc <= i_wb_dat[SLMR_CFG_SRC_BIT];
        end
    end

    always_ff @(posedge i_core_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            irq_en <= SLMR_EV_RST;
        end else if (wb_wr && wb_idx == SLMR_IDX_IRQ_EN && i_wb_sel[0]) begin
            irq_en <= i_wb_dat[SLMR_EV_W-1:0];
        end
    end

    // ==========================================================
    // Comparators
    slmr_cmp u_cmp (
        .i_core_clk   (i_core_clk),
        .i_rst_b      (i_rst_b),
        .i_src_enc    (src_enc),
        .i_enc_pos    (i_enc_pos),
        .i_actual_pos (i_actual_pos),
        .i_limits     (limits),
        .o_stop_left  (o_stop_left),
        .o_stop_right (o_stop_right)
    );

    // ==========================================================
    // Stop events into sticky status; a new event beats a clear
    always_comb begin
        stop_now      = {o_stop_right, o_stop_left};
        ev_set        = stop_now & ~stop_prev;
        ev_clr        = (wb_wr && wb_idx == SLMR_IDX_IRQ_CLR && i_wb_sel[0]) ? i_wb_dat[SLMR_EV_W-1:0] : '0;
        next_irq_stat = (irq_stat & ~ev_clr) | ev_set;
    end

    always_ff @(posedge i_core_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            stop_prev <= SLMR_EV_RST;
        end else begin
            stop_prev <= stop_now;
        end
    end

    always_ff @(posedge i_core_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            irq_stat <= SLMR_EV_RST;
        end else begin
            irq_stat <= next_irq_stat;
        end
    end

    // Built from next values so the pin tracks status without lag
    always_ff @(posedge i_core_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_irq <= 1'b0;
        end else begin
            o_irq <= |(next_irq_stat & irq_en);
        end
    end

    // ==========================================================
    // Sine table lookup and readback
    always_ff @(posedge i_core_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_tbl_addr.addr_b <= SLMR_MSIDX_RST;
            o_tbl_addr.addr_a <= SLMR_PHASE_A_OFS;
        end else begin
            o_tbl_addr.addr_b <= i_microstep_index;
            o_tbl_addr.addr_a <= i_microstep_index + SLMR_PHASE_A_OFS;
        end
    end

    // Index delayed one cycle behind the table address; the current readback, registered after the table, trails it by one more cycle
    always_ff @(posedge i_core_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            microstep_index <= SLMR_MSIDX_RST;
        end else begin
            microstep_index <= o_tbl_addr.addr_b;
        end
    end

    // Table answers one cycle after the address; raw, no current scaling
    always_ff @(posedge i_core_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            phase_current.phase_a_current <= SLMR_PHASE_A_CURRENT_RST;
            phase_current.phase_b_current <= SLMR_PHASE_B_CURRENT_RST;
        end else begin
            phase_current <= i_tbl_data;
        end
    end

    // ==========================================================
    // Read data; unmapped and write-only words read zero
    always_comb begin
        next_rd_data = '0;
        unique case (wb_idx)
            SLMR_IDX_LEFT: begin
                next_rd_data = limits.left;
            end
            SLMR_IDX_RIGHT: begin
                next_rd_data = limits.right;
            end
            SLMR_IDX_MSIDX: begin
                next_rd_data[SLMR_MSIDX_W-1:0] = microstep_index;
            end
            SLMR_IDX_CUR: begin
                next_rd_data[SLMR_PHASE_B_CURRENT_LSB +: SLMR_CUR_W] = phase_current.phase_b_current;
                next_rd_data[SLMR_PHASE_A_CURRENT_LSB +: SLMR_CUR_W] = phase_current.phase_a_current;
            end
            SLMR_IDX_CFG: begin
                next_rd_data[SLMR_CFG_SRC_BIT] = src_enc;
            end
            SLMR_IDX_IRQ_STAT: begin
                next_rd_data[SLMR_EV_W-1:0] = irq_stat;
            end
            SLMR_IDX_IRQ_EN: begin
                next_rd_data[SLMR_EV_W-1:0] = irq_en;
            end
            default: begin
                next_rd_data = '0;
            end
        endcase
    end

    always_ff @(posedge i_core_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_wb_dat <= '0;
        end else if (wb_req && !i_wb_we) begin
            o_wb_dat <= next_rd_data;
        end
    end

    // ==========================================================
    // Assertions
    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (!i_rst_b);

    sequence bus_req_s;
        i_wb_cyc && i_wb_stb && !o_wb_ack;
    endsequence

    sequence full_write_s(logic [8:0] idx);
        bus_req_s ##0 (i_wb_we && wb_idx == idx && i_wb_sel == 4'hf);
    endsequence

    sequence read_s(logic [8:0] idx);
        bus_req_s ##0 (!i_wb_we && wb_idx == idx);
    endsequence

    ack_latency_a: assert property (bus_req_s |=> o_wb_ack ##1 !o_wb_ack)
        else $error("ack not one pulse after request");

    left_write_a: assert property (full_write_s(SLMR_IDX_LEFT) |=> limits.left == $past(i_wb_dat))
        else $error("left limit write lost");

    right_readback_a: assert property (full_write_s(SLMR_IDX_RIGHT) ##3 read_s(SLMR_IDX_RIGHT)
                                       |=> o_wb_dat == $past(i_wb_dat, 4))
        else $error("right limit readback mismatch");

    phase_offset_a: assert property (o_tbl_addr.addr_a == 10'(o_tbl_addr.addr_b + SLMR_PHASE_A_OFS))
        else $error("phase A address not offset by 256");

    index_follow_a: assert property (##2 microstep_index == $past(i_microstep_index, 2))
        else $error("microstep index readback not two cycles behind");

    cur_read_a: assert property (read_s(SLMR_IDX_CUR)
                                 |=> o_wb_dat == {7'h00, $past(phase_current.phase_b_current),
                                                  7'h00, $past(phase_current.phase_a_current)})
        else $error("phase current readback wrong");

    index_read_a: assert property (read_s(SLMR_IDX_MSIDX) |=> o_wb_dat == {22'h00_0000, $past(microstep_index)})
        else $error("microstep index readback wrong");

    set_wins_a: assert property ((ev_set[SLMR_EV_LEFT] && ev_clr[SLMR_EV_LEFT]) |=> irq_stat[SLMR_EV_LEFT])
        else $error("left stop event lost to clear");

    irq_level_a: assert property (##1 o_irq == |(irq_stat & $past(irq_en)))
        else $error("interrupt level disagrees with status");

    stop_event_a: assert property ($rose(o_stop_right) |=> irq_stat[SLMR_EV_RIGHT])
        else $error("right stop did not set status");

endmodule : slmr_top

// File: dv/slmr_top_test.sv
// Self-checking bench: soft limit stops, readback, interrupts over Wishbone
module slmr_top_test
    import slmr_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    // ==========================================================
    // Clock, reset, design inputs
    logic                    i_core_clk = 1'b0;
    logic                    i_rst_b    = 1'b0;
    logic                    wb_cyc     = 1'b0;
    logic                    wb_stb     = 1'b0;
    logic                    wb_we      = 1'b0;
    logic [SLMR_AW-1:0]      wb_adr     = '0;
    logic [SLMR_SELW-1:0]    wb_sel     = '0;
    logic [SLMR_DW-1:0]      wb_wdat    = '0;
    logic [SLMR_DW-1:0]      wb_rdat;
    logic                    wb_ack;
    logic signed [31:0]      enc_pos    = '0;
    logic signed [31:0]      act_pos    = '0;
    logic [SLMR_MSIDX_W-1:0] ms_index   = '0;
    slmr_tbl_addr_t          tbl_addr;
    slmr_cur_t               tbl_data   = '0;
    logic                    stop_left;
    logic                    stop_right;
    logic                    irq;
    int                      n_fail     = 0;
    int                      tests_run  = 0;

    always #12.5 i_core_clk = ~i_core_clk;

    slmr_top slmr_top_i (
        .i_core_clk        (i_core_clk),
        .i_rst_b           (i_rst_b),
        .i_wb_cyc          (wb_cyc),
        .i_wb_stb          (wb_stb),
        .i_wb_we           (wb_we),
        .i_wb_adr          (wb_adr),
        .i_wb_sel          (wb_sel),
        .i_wb_dat          (wb_wdat),
        .o_wb_dat          (wb_rdat),
        .o_wb_ack          (wb_ack),
        .i_enc_pos         (enc_pos),
        .i_actual_pos      (act_pos),
        .i_microstep_index (ms_index),
        .o_tbl_addr        (tbl_addr),
        .i_tbl_data        (tbl_data),
        .o_stop_left       (stop_left),
        .o_stop_right      (stop_right),
        .o_irq             (irq)
    );

    // ==========================================================
    // Sine table stand-in: one-cycle synchronous read
    function automatic logic [8:0] tbl_word(input logic [9:0] a);
        return a[8:0] ^ {a[9], 8'h5a};
    endfunction : tbl_word

    always_ff @(posedge i_core_clk) begin
        tbl_data <= '{phase_b_current: tbl_word(tbl_addr.addr_b), phase_a_current: tbl_word(tbl_addr.addr_a)};
    end

    // ==========================================================
    // Verdict, compare and bus tasks
    task automatic give_verdict();
        if (n_fail == 0 && tests_run > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : give_verdict

    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        tests_run++;
        if (got !== exp) begin
            $display("Error %s expected %h seen %h", name, exp, got);
            n_fail++;
        end
    endtask : chk

    // Entered and left at a rising edge; one idle cycle follows every access
    task automatic wb_xfer(input logic we, input logic [8:0] idx, input logic [3:0] sel,
                           input logic [31:0] dat, output logic [31:0] rdat);
        wb_cyc  <= 1'b1;
        wb_stb  <= 1'b1;
        wb_we   <= we;
        wb_adr  <= {idx, 2'b00};
        wb_sel  <= sel;
        wb_wdat <= dat;
        // Request stands until ack is seen at a rising edge; only the watchdog ends a hang
        do begin
            @(posedge i_core_clk);
        end while (wb_ack !== 1'b1);
        rdat = wb_rdat;
        wb_cyc <= 1'b0;
        wb_stb <= 1'b0;
        wb_we  <= 1'b0;
        @(posedge i_core_clk);
        chk("wb_ack_drop", 32'h0000_0000, {31'h0, wb_ack});
    endtask : wb_xfer

    task automatic wr(input logic [8:0] idx, input logic [31:0] dat, input logic [3:0] sel = 4'hf);
        logic [31:0] dummy;
        wb_xfer(1'b1, idx, sel, dat, dummy);
    endtask : wr

    task automatic rd(input string name, input logic [8:0] idx, input logic [31:0] exp);
        logic [31:0] got;
        wb_xfer(1'b0, idx, 4'hf, 32'h0000_0000, got);
        chk(name, exp, got);
    endtask : rd

    // Positions settle for three edges before the stops are looked at
    task automatic stop_case(input logic src, input logic [31:0] enc, input logic [31:0] act,
                             input logic exp_l, input logic exp_r);
        wr(SLMR_IDX_CFG, {31'h0, src});
        enc_pos <= enc;
        act_pos <= act;
        repeat (3) @(posedge i_core_clk);
        @(negedge i_core_clk);
        chk("stop_left", {31'h0, exp_l}, {31'h0, stop_left});
        chk("stop_right", {31'h0, exp_r}, {31'h0, stop_right});
        @(posedge i_core_clk);
    endtask : stop_case

    task automatic irq_chk(input logic exp);
        @(negedge i_core_clk);
        chk("irq", {31'h0, exp}, {31'h0, irq});
        @(posedge i_core_clk);
    endtask : irq_chk

    // ==========================================================
    // Watchdog: the whole sequence needs well under 5000 cycles
    initial begin
        repeat (20000) @(posedge i_core_clk);
        n_fail++;
        give_verdict();
    end

    // ==========================================================
    // Main sequence
    logic [9:0] idx_list [6] = '{10'h000, 10'h005, 10'h0ff, 10'h100, 10'h2ff, 10'h3ff};
    logic [9:0] ia;
    initial begin
        repeat (8) @(posedge i_core_clk);
        i_rst_b <= 1'b1;
        @(posedge i_core_clk);
        rd("left_reset", SLMR_IDX_LEFT, 32'h0000_0000);
        rd("right_reset", SLMR_IDX_RIGHT, 32'h0000_0000);
        rd("index_reset", SLMR_IDX_MSIDX, 32'h0000_0000);
        // Full signed range and byte lanes
        wr(SLMR_IDX_LEFT, 32'h8000_0000);
        rd("left_min", SLMR_IDX_LEFT, 32'h8000_0000);
        wr(SLMR_IDX_RIGHT, 32'h7fff_ffff);
        rd("right_max", SLMR_IDX_RIGHT, 32'h7fff_ffff);
        wr(SLMR_IDX_LEFT, 32'hffff_fffb);
        wr(SLMR_IDX_LEFT, 32'haabb_ccdd, 4'b0010);
        rd("left_lane1", SLMR_IDX_LEFT, 32'hffff_ccfb);
        wr(SLMR_IDX_LEFT, 32'hffff_fffb);
        wr(SLMR_IDX_RIGHT, 32'h0000_000a);
        rd("unmapped", 9'h03f, 32'h0000_0000);
        // Stops: left -5, right 10, both sources, signed boundaries
        stop_case(1'b0, 32'h0000_0000, 32'hffff_fffb, 1'b1, 1'b0);
        stop_case(1'b0, 32'hffff_fffb, 32'hffff_fffc, 1'b0, 1'b0);
        stop_case(1'b0, 32'h0000_0000, 32'h0000_000a, 1'b0, 1'b1);
        stop_case(1'b0, 32'h0000_000a, 32'h0000_0009, 1'b0, 1'b0);
        stop_case(1'b0, 32'h0000_0064, 32'h8000_0000, 1'b1, 1'b0);
        stop_case(1'b1, 32'hffff_fffb, 32'h0000_0064, 1'b1, 1'b0);
        stop_case(1'b1, 32'hffff_fffc, 32'hffff_ff9c, 1'b0, 1'b0);
        stop_case(1'b1, 32'h0000_000a, 32'h0000_0000, 1'b0, 1'b1);
        stop_case(1'b1, 32'h7fff_ffff, 32'h8000_0000, 1'b0, 1'b1);
        stop_case(1'b1, 32'h0000_0009, 32'h0000_000a, 1'b0, 1'b0);
        // Interrupt: raise, clear, mask, unmask
        stop_case(1'b0, 32'h0000_0000, 32'h0000_0000, 1'b0, 1'b0);
        wr(SLMR_IDX_IRQ_CLR, 32'h0000_0003);
        wr(SLMR_IDX_IRQ_EN, 32'h0000_0001);
        rd("irq_en", SLMR_IDX_IRQ_EN, 32'h0000_0001);
        stop_case(1'b0, 32'h0000_0000, 32'hffff_fffb, 1'b1, 1'b0);
        irq_chk(1'b1);
        rd("irq_stat_l", SLMR_IDX_IRQ_STAT, 32'h0000_0001);
        rd("irq_clr_rd", SLMR_IDX_IRQ_CLR, 32'h0000_0000);
        wr(SLMR_IDX_IRQ_CLR, 32'h0000_0001);
        irq_chk(1'b0);
        rd("irq_stat_c", SLMR_IDX_IRQ_STAT, 32'h0000_0000);
        wr(SLMR_IDX_IRQ_EN, 32'h0000_0000);
        stop_case(1'b0, 32'h0000_0000, 32'h0000_0014, 1'b0, 1'b1);
        irq_chk(1'b0);
        rd("irq_stat_r", SLMR_IDX_IRQ_STAT, 32'h0000_0002);
        wr(SLMR_IDX_IRQ_EN, 32'h0000_0002);
        irq_chk(1'b1);
        wr(SLMR_IDX_IRQ_CLR, 32'h0000_0002);
        irq_chk(1'b0);
        // Left stop rises in the very cycle its clear is taken: the set must win
        act_pos <= 32'hffff_fffb;
        @(posedge i_core_clk);
        wr(SLMR_IDX_IRQ_CLR, 32'h0000_0001);
        rd("irq_set_wins", SLMR_IDX_IRQ_STAT, 32'h0000_0001);
        irq_chk(1'b0);
        // Microstep index and phase currents, wrap of the A offset
        foreach (idx_list[k]) begin
            ms_index <= idx_list[k];
            repeat (4) @(posedge i_core_clk);
            ia = idx_list[k] + SLMR_PHASE_A_OFS;
            rd("ms_index", SLMR_IDX_MSIDX, {22'h0, idx_list[k]});
            rd("phase_cur", SLMR_IDX_CUR,
               {7'h0, tbl_word(idx_list[k]), 7'h0, tbl_word(ia)});
        end
        // Read-only words ignore writes
        wr(SLMR_IDX_MSIDX, 32'hffff_ffff);
        wr(SLMR_IDX_CUR, 32'hffff_ffff);
        rd("ms_index_ro", SLMR_IDX_MSIDX, 32'h0000_03ff);
        rd("phase_cur_ro", SLMR_IDX_CUR,
           {7'h0, tbl_word(10'h3ff), 7'h0, tbl_word(10'h0ff)});
        // Park at index zero, as software must before any table reload
        ms_index <= '0;
        repeat (4) @(posedge i_core_clk);
        rd("ms_index_zero", SLMR_IDX_MSIDX, 32'h0000_0000);
        give_verdict();
    end
endmodule : slmr_top_test
